// ### hw/exc_apb_regs.sv
// APB slave for pending flags, group enables and the arbitration status.
// Assumes a single APB master on CLK_IN; answers in the access cycle.
`timescale 1ns/1ps
`include "exc_arb_params.svh"
module exc_apb_regs (
  input  wire logic        clk_in,       // Clock
  input  wire logic        rst_in,       // Async reset, high
  input  wire logic        psel_in,      // APB select
  input  wire logic        penable_in,   // APB enable
  input  wire logic        pwrite_in,    // APB write
  input  wire logic [15:0] paddr_in,     // APB address
  input  wire logic [31:0] pwdata_in,    // APB write data
  output logic      [31:0] prdata_out,   // APB read data (reg)
  output logic             pslverr_out,  // Unmapped access
  input  wire logic [23:0] pend_in,      // Pending flags 1..24
  input  wire logic [6:0]  status_in,    // Latched flag, trap flag and level
  output logic      [31:0] grp_ena_out   // Per-event enables of shared groups
);
  logic [31:0] grp_ena_q, grp_ena_d;
  logic [31:0] prdata_q, prdata_d;
  logic        access;
  logic        mapped;

  assign access      = psel_in & penable_in;
  assign prdata_out  = prdata_q;
  assign grp_ena_out = grp_ena_q;

  always_comb
  begin
    grp_ena_d = grp_ena_q;
    prdata_d  = prdata_q;
    mapped    = 1'b1;
    unique case (paddr_in)
      `OFS_PEND_FIRST:  prdata_d = {24'h000000, pend_in[5:0], 2'b00}; // see (RULE14)
      `OFS_PEND_SECOND: prdata_d = {24'h000000, pend_in[13:6]};       // see (RULE19)
      `OFS_PEND_THIRD:  prdata_d = {24'h000000, pend_in[21:14]};
      `OFS_PEND_FOURTH: prdata_d = {30'h00000000, pend_in[23:22]};    // see (RULE20)
      `OFS_GROUP_ENA:   prdata_d = grp_ena_q;
      `OFS_ARB_STATUS:  prdata_d = {25'h0000000, status_in};
      default:
      begin
        prdata_d = 32'h0000_0000;
        mapped   = 1'b0;
      end
    endcase
    // Status registers ignore writes; only the enable word is writable
    if (access && pwrite_in && paddr_in == `OFS_GROUP_ENA)
      grp_ena_d = pwdata_in;
    // Loaded at the setup edge so read data stands through the access edge
    if (!(psel_in && !penable_in && !pwrite_in))
      prdata_d = prdata_q;
  end

  assign pslverr_out = access & ~mapped;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      grp_ena_q <= `GROUP_ENA_RESET;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      grp_ena_q <= grp_ena_d;
      prdata_q  <= prdata_d;
    end
  end
endmodule

// ### hw/exc_arb_params.svh
// Constants for the exception arbitration unit: offsets, resets, vectors.
// Included by the register and unit design files; definitions only.
`ifndef EXC_ARB_PARAMS_SVH
`define EXC_ARB_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (APB byte addresses)
// ------------------------------------------------------------
`define OFS_PEND_FIRST   16'hFE04
`define OFS_PEND_SECOND  16'hFE05
`define OFS_PEND_THIRD   16'hFE06
`define OFS_PEND_FOURTH  16'hFE07
`define OFS_GROUP_ENA    16'hFE10
`define OFS_CCR_MASK     16'hFE14
`define OFS_ARB_STATUS   16'hFE18

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define PEND_FIRST_LSB   2
`define PEND_RESET       8'h00
`define GROUP_ENA_RESET  32'h0000_0000

// ------------------------------------------------------------
// Priorities and vectors
// ------------------------------------------------------------
`define NUM_SOURCES      24
`define PRIO_TRAP        5'h00
`define PRIO_LOWEST      5'h18
`define VEC_RESET        16'hFFFE
`define VEC_TRAP         16'hFFFC
`define VEC_LAST         16'hFFCC

`endif

// ### hw/exc_arb_pkg.sv
// Types shared by the exception arbitration unit files.
// Assumes exc_arb_params.svh is on the include path.
package exc_arb_pkg;
  typedef enum logic [2:0]
  {
    ST_RUN   = 3'b000,
    ST_STACK = 3'b001,
    ST_VECHI = 3'b010,
    ST_VECLO = 3'b011,
    ST_DONE  = 3'b100
  } arb_state_t;

  typedef struct packed
  {
    logic        boundary;   // Instruction completes this cycle
    logic        trap;       // Software trap instruction executing
    logic        ret;        // Return instruction executing
    logic        mask_clear; // Core clears global mask
  } core_evt_t;

  typedef struct packed
  {
    logic        stack_push;   // Push context (pulse)
    logic        stack_pop;    // Pop context (pulse)
    logic        push_index_hi;// Always 0: high index byte never stacked
    logic        pc_minus_one; // Stacked PC is PC-1
    logic        discard_fetch;// Drop prefetched opcode
    logic [15:0] vec_addr;     // Vector byte address to fetch
    logic        vec_rd;       // Vector fetch strobe
  } core_cmd_t;
endpackage

// ### hw/exc_prio_enc.sv
// Fixed priority encoder over pending requests; lowest index wins.
// Assumes requests already gated by enables.
`timescale 1ns/1ps
module exc_prio_enc #(
  parameter int N = 24
) (
  input  wire logic [N-1:0] req_in,    // Gated requests, bit0 = level 1
  output logic              any_out,   // Some request present
  output logic [4:0]        level_out  // Winning level, 1..N
);
  always_comb
  begin
    any_out   = 1'b0;
    level_out = 5'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        any_out   = 1'b1;
        level_out = 5'(i + 1); // see (RULE15)
      end
    end
  end
endmodule

// ### hw/exception_arbitration_unit.sv
// Exception arbitration unit: latches, masks and arbitrates interrupt
// requests, sequences entry/return handshakes with the core.
// Assumes the core reports instruction boundaries on the same clock.
//
// Notes on behaviour
// (RULE1) Entry pushes context, then sets the global mask. The unit pulses the mask set in the same cycle as the push.
// (RULE2) Return pops the saved context to resume the program.
// (RULE3) Requests are latched and arbitrated at entry; level picks the vector.
// (RULE4) A latched request is not displaced until serviced or mask cleared.
// (RULE5) Hardware requests start only at an instruction boundary.
// (RULE6) At a boundary, take request only if mask clear and enabled.
// (RULE7) Among several enabled requests the highest priority wins.
// (RULE8) Pending request at return is serviced first; prefetch discarded.
// (RULE9) High index byte is never pushed on entry.
// (RULE10) Software trap always enters, regardless of the mask.
// (RULE11) Trap stacks PC; hardware interrupt stacks PC minus one.
// (RULE12) Global mask blocks every source except the software trap.
// (RULE13) Pending flag is 1 while its request is present, else 0.
// (RULE14) First status register: flags six..one in bits 7..2, read-only.
// (RULE15) Levels run 0 highest to 24 lowest; trap at 0, pin at 1.
// (RULE16) Each level owns a two-byte vector, stepping down from the top.
// (RULE17) Shared groups request the OR of each flag ANDed with its enable.
// (RULE18) Vector fetch reads high byte from even, low byte from odd.
// (RULE19) Second status register: flags fourteen..seven, read-only, reset zero.
// (RULE20) Fourth status register: flags 24 and 23 in bits 1..0.
`timescale 1ns/1ps
`include "exc_arb_params.svh"
module exception_arbitration_unit
  import exc_arb_pkg::*;
#(
  parameter int N_SRC = `NUM_SOURCES
) (
  input  wire logic                 CLK_IN,        // 40 MHz bus clock
  input  wire logic                 SYS_RST_IN,    // Async reset, high
  input  wire logic                 PSEL_IN,       // APB select
  input  wire logic                 PENABLE_IN,    // APB enable
  input  wire logic                 PWRITE_IN,     // APB write
  input  wire logic [15:0]          PADDR_IN,      // APB address
  input  wire logic [31:0]          PWDATA_IN,     // APB write data
  output logic      [31:0]          PRDATA_OUT,    // APB read data
  output logic                      PREADY_OUT,    // APB ready
  output logic                      PSLVERR_OUT,   // APB error
  input  wire logic [N_SRC-1:0]     SRC_FLAG_IN,   // Source flags, bit0 = level 1
  input  wire logic [N_SRC-1:0]     SRC_ENA_IN,    // Source enables
  input  wire logic [5:0]           SPI_ERR_FLAG_IN, // Shared group event flags
  input  wire logic [5:0]           SCI_ERR_FLAG_IN, // Shared group event flags
  input  wire logic                 CCR_MASK_IN,   // Global mask bit from core
  input  wire core_evt_t            CORE_EVT_IN,   // Core events
  output core_cmd_t                 CORE_CMD_OUT,  // Commands to core
  output logic                      MASK_SET_OUT,  // Set the global mask (pulse)
  output logic      [4:0]           LEVEL_OUT      // Latched priority level
);
  // ------------------------------------------------------------
  // Request gating
  // ------------------------------------------------------------
  logic [31:0]      grp_ena;
  logic [N_SRC-1:0] raw_req;
  logic [N_SRC-1:0] gated_req;
  logic             any_req;
  logic [4:0]       win_level;

  // Shared groups feed levels 9 and 11 (indices 8 and 10)
  always_comb
  begin
    raw_req     = SRC_FLAG_IN;
    raw_req[8]  = SRC_FLAG_IN[8]  | (|(SPI_ERR_FLAG_IN & grp_ena[5:0]));  // see (RULE17)
    raw_req[10] = SRC_FLAG_IN[10] | (|(SCI_ERR_FLAG_IN & grp_ena[13:8])); // see (RULE17)
  end

  assign gated_req = raw_req & SRC_ENA_IN; // see (RULE6)

  exc_prio_enc #(
    .N (N_SRC)
  ) u_enc (
    .req_in    (gated_req),
    .any_out   (any_req),
    .level_out (win_level)
  );

  // ------------------------------------------------------------
  // Entry / return sequencer
  // ------------------------------------------------------------
  arb_state_t  state_q, state_d;
  logic [4:0]  level_q, level_d;
  logic        is_trap_q, is_trap_d;
  logic        latched_q, latched_d;
  core_cmd_t   cmd_d, cmd_q;
  logic        mask_set_d, mask_set_q;

  function automatic logic [15:0] vec_of(input logic [4:0] lvl);
    // Level 0 is the trap; each further level steps two bytes down
    vec_of = 16'(`VEC_TRAP - {10'h000, lvl, 1'b0}); // see (RULE16)
  endfunction

  always_comb
  begin
    state_d    = state_q;
    level_d    = level_q;
    is_trap_d  = is_trap_q;
    latched_d  = latched_q;
    cmd_d      = '0;
    mask_set_d = 1'b0;
    // Clearing the mask releases a latch that has not started stacking
    if (latched_q && CORE_EVT_IN.mask_clear && state_q == ST_RUN)
      latched_d = 1'b0; // see (RULE4)
    unique case (state_q)
      ST_RUN:
      begin
        if (CORE_EVT_IN.ret)
        begin
          cmd_d.stack_pop = 1'b1; // see (RULE2)
          if (any_req)
          begin
            // Pop restores the mask to clear; go straight into service
            cmd_d.discard_fetch = 1'b1; // see (RULE8)
            level_d   = win_level;
            is_trap_d = 1'b0;
            latched_d = 1'b1;
            state_d   = ST_STACK;
          end
        end
        else if (CORE_EVT_IN.boundary) // see (RULE5)
        begin
          if (CORE_EVT_IN.trap)
          begin
            level_d   = `PRIO_TRAP; // see (RULE10)
            is_trap_d = 1'b1;
            latched_d = 1'b1;
            state_d   = ST_STACK;
          end
          else if (latched_q && !CCR_MASK_IN)
            state_d = ST_STACK; // see (RULE4)
          else if (any_req && !CCR_MASK_IN) // see (RULE12)
          begin
            level_d   = win_level; // see (RULE7)
            is_trap_d = 1'b0;
            latched_d = 1'b1; // see (RULE3)
            state_d   = ST_STACK;
          end
        end
      end
      ST_STACK:
      begin
        cmd_d.stack_push    = 1'b1; // see (RULE1)
        cmd_d.push_index_hi = 1'b0; // see (RULE9)
        cmd_d.pc_minus_one  = ~is_trap_q; // see (RULE11)
        mask_set_d          = 1'b1; // see (RULE1)
        state_d             = ST_VECHI;
      end
      ST_VECHI:
      begin
        cmd_d.vec_rd   = 1'b1;
        cmd_d.vec_addr = vec_of(level_q); // see (RULE18)
        state_d        = ST_VECLO;
      end
      ST_VECLO:
      begin
        cmd_d.vec_rd   = 1'b1;
        cmd_d.vec_addr = vec_of(level_q) | 16'h0001; // see (RULE18)
        state_d        = ST_DONE;
      end
      ST_DONE:
      begin
        latched_d = 1'b0;
        state_d   = ST_RUN;
      end
      default:
        state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q    <= ST_RUN;
      level_q    <= 5'h00;
      is_trap_q  <= 1'b0;
      latched_q  <= 1'b0;
      cmd_q      <= '0;
      mask_set_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      level_q    <= level_d;
      is_trap_q  <= is_trap_d;
      latched_q  <= latched_d;
      cmd_q      <= cmd_d;
      mask_set_q <= mask_set_d;
    end
  end

  assign CORE_CMD_OUT = cmd_q;
  assign MASK_SET_OUT = mask_set_q;
  assign LEVEL_OUT    = level_q;
  assign PREADY_OUT   = 1'b1;

  // ------------------------------------------------------------
  // Status registers
  // ------------------------------------------------------------
  // Flags follow live requests so they read as present, not as history
  exc_apb_regs u_regs (
    .clk_in      (CLK_IN),
    .rst_in      (SYS_RST_IN),
    .psel_in     (PSEL_IN),
    .penable_in  (PENABLE_IN),
    .pwrite_in   (PWRITE_IN),
    .paddr_in    (PADDR_IN),
    .pwdata_in   (PWDATA_IN),
    .prdata_out  (PRDATA_OUT),
    .pslverr_out (PSLVERR_OUT),
    .pend_in     (raw_req), // see (RULE13)
    .status_in   ({latched_q, is_trap_q, level_q}),
    .grp_ena_out (grp_ena)
  );
endmodule

// ### tb/core_model.sv
// Core model: keeps the global mask and gathers each two-byte vector fetch.
// Assumes the command pulses of exc_arb_pkg on the same clock.
`timescale 1ns/1ps
module core_model
  import exc_arb_pkg::*;
(
  input  wire logic       clk_in,   // Clock
  input  wire logic       rst_in,   // Reset
  input  wire core_cmd_t  cmd_in,   // Unit commands
  input  wire logic       mset_in,  // Mask set pulse
  input  wire core_evt_t  evt_in,   // Core events
  output logic            mask_out, // Global mask
  output logic            done_out, // Vector fetched
  output logic [16:0]     got_out   // {pc minus one, vector}
);
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      mask_out <= 1'b0;
      done_out <= 1'b0;
      got_out  <= '0;
    end
    else
    begin
      // Odd byte must follow the even one, else no completion is seen
      done_out <= cmd_in.vec_rd && cmd_in.vec_addr == got_out[15:0] + 16'h0001;
      if (cmd_in.stack_push)
        got_out[16] <= cmd_in.pc_minus_one;
      if (cmd_in.vec_rd && !cmd_in.vec_addr[0])
        got_out[15:0] <= cmd_in.vec_addr;
      if (mset_in)
        mask_out <= 1'b1;
      else if (evt_in.ret || evt_in.mask_clear)
        mask_out <= 1'b0;
    end
endmodule

// ### tb/exc_arb_monitor.sv
// Checker for the exception arbitration unit: entry, return, vector fetch.
// Assumes the core event and command structs of exc_arb_pkg.
`timescale 1ns/1ps
module exc_arb_monitor
  import exc_arb_pkg::*;
(
  input wire logic       CLK_IN,       // Clock
  input wire logic       SYS_RST_IN,   // Reset
  input wire core_evt_t  CORE_EVT_IN,  // Core events
  input wire core_cmd_t  CORE_CMD_OUT, // Core commands
  input wire logic       MASK_SET_OUT, // Mask set pulse
  input wire logic [4:0] LEVEL_OUT     // Latched level
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  push_mask_a:
    assert property (CORE_CMD_OUT.stack_push == MASK_SET_OUT) else $error("mask pulse off push");
  ret_pop_a:
    assert property (CORE_EVT_IN.ret |=> CORE_CMD_OUT.stack_pop) else $error("no pop on return");
  index_hi_a:
    assert property (!CORE_CMD_OUT.push_index_hi) else $error("high index byte pushed");
  trap_entry_a:
    assert property (CORE_EVT_IN.trap |-> ##2 CORE_CMD_OUT.stack_push) else $error("trap lost");
  pc_kind_a:
    assert property (CORE_CMD_OUT.stack_push |-> CORE_CMD_OUT.pc_minus_one == (LEVEL_OUT != 0))
      else $error("wrong stacked pc kind");
  vec_hi_a:
    assert property (CORE_CMD_OUT.stack_push |=> CORE_CMD_OUT.vec_rd && !CORE_CMD_OUT.vec_addr[0])
      else $error("high vector byte not fetched");
  vec_lo_a:
    assert property (CORE_CMD_OUT.vec_rd && !CORE_CMD_OUT.vec_addr[0] |=> CORE_CMD_OUT.vec_rd
      && CORE_CMD_OUT.vec_addr == $past(CORE_CMD_OUT.vec_addr) + 16'h0001) else $error("bad lo");
  vec_level_a:
    assert property (CORE_CMD_OUT.vec_rd && !CORE_CMD_OUT.vec_addr[0] |->
      CORE_CMD_OUT.vec_addr == 16'hFFFC - {10'h000, LEVEL_OUT, 1'b0}) else $error("bad vector");
endmodule
bind exception_arbitration_unit exc_arb_monitor mon_i (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .CORE_EVT_IN(CORE_EVT_IN), .CORE_CMD_OUT(CORE_CMD_OUT), .MASK_SET_OUT(MASK_SET_OUT),
  .LEVEL_OUT(LEVEL_OUT));

// ### tb/testbench.sv
// Testbench: APB status reads, arbitration, mask, trap and return cases.
// Assumes the core model on the far side and zero-wait APB.
`timescale 1ns/1ps
module testbench;
  import exc_arb_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, perr, er, mset, mask, done;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] flag, ena, f, g;
  logic [5:0]  spi;
  logic [16:0] got;
  core_evt_t   evt;
  core_cmd_t   cmd;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  logic [4:0]  lvl;
  int          err_count, num_checks, cyc;

  exception_arbitration_unit exception_arbitration_unit_i (.CLK_IN(clk), .SYS_RST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
    .SRC_FLAG_IN(flag), .SRC_ENA_IN(ena), .SPI_ERR_FLAG_IN(spi), .SCI_ERR_FLAG_IN(6'h00),
    .CCR_MASK_IN(mask), .CORE_EVT_IN(evt), .CORE_CMD_OUT(cmd), .MASK_SET_OUT(mset),
    .LEVEL_OUT(lvl));
  core_model core_model_i (.clk_in(clk), .rst_in(rst), .cmd_in(cmd), .mset_in(mset),
    .evt_in(evt), .mask_out(mask), .done_out(done), .got_out(got));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    er = perr;
    // Read data was loaded at the setup edge and stands here
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ev(input logic [3:0] e);
    @(posedge clk);
    evt <= core_evt_t'(e);
    @(posedge clk);
    evt <= '0;
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [16:0] hw_vec(input logic [23:0] r);
    for (int i = 0; i < 24; i++)
      if (r[i])
        return {1'b1, 16'hFFFC - 16'(2 * (i + 1))};
    return '0;
  endfunction

  always @(posedge clk)
  begin
    cyc++;
    if (done)
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 17'h1FFFF;
      chk(32'(got), 32'(e));
      chk(32'(lvl), 32'(16'(16'hFFFC - e[15:0]) >> 1));
    end
    if (cyc == 4000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, flag, ena, spi} = '1;
    {psel, penable, pwrite, paddr, pwdata, flag, ena, spi} = '0;
    evt = '0;
    void'($urandom(44));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 16'hFE04, 32'h0);
    chk(rd, 32'h0);
    f = $urandom;
    @(posedge clk);
    flag <= f;
    ev(4'h8); // Disabled sources must not enter
    apb(1'b1, 16'hFE04, 32'hFF);
    apb(1'b0, 16'hFE04, 32'h0);
    chk(rd, {24'h0, f[5:0], 2'b00});
    apb(1'b0, 16'hFE05, 32'h0);
    chk(rd, {24'h0, f[13:6]});
    apb(1'b0, 16'hFE07, 32'h0);
    chk(rd, {30'h0, f[23:22]});
    apb(1'b0, 16'hFE20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (int k = 0; k < 10; k++)
    begin
      f = $urandom | 24'h800000;
      g = $urandom | 24'h800000;
      @(posedge clk);
      flag <= f;
      ena <= g;
      exp_q.push_back(hw_vec(f & g));
      ev(4'h8);
      @(posedge clk);
      flag <= '0;
      ev(4'h2);
    end
    @(posedge clk);
    ena <= '1;
    spi <= 6'h04;
    ev(4'h8); // Group enables still clear
    apb(1'b1, 16'hFE10, 32'h3F);
    exp_q.push_back({1'b1, 16'hFFEA});
    ev(4'h8);
    @(posedge clk);
    spi <= '0;
    ev(4'h2);
    @(posedge clk);
    flag <= 24'h000020;
    exp_q.push_back({1'b1, 16'hFFF0});
    @(posedge clk);
    evt <= core_evt_t'(4'h8);
    @(posedge clk);
    evt <= '0;
    flag <= 24'h000021;
    repeat (6) @(posedge clk);
    ev(4'h8); // Mask set: ignored
    exp_q.push_back({1'b0, 16'hFFFC});
    ev(4'hC);
    exp_q.push_back({1'b1, 16'hFFFA});
    ev(4'h2);
    @(posedge clk);
    flag <= '0;
    ev(4'h2);
    chk(exp_q.size(), 32'h0);
    final_report();
  end
endmodule
